/* shared/bmtc_pkg.sv */
// bmtc_pkg: constants and types of the backup module transfer controller
// assumes a single 200 MHz clock and a classic wishbone register slave
package bmtc_pkg;
   // clock and lamp timing
   localparam int CLK_HZ = 200_000_000;
   localparam int SLOW_PERIOD_MS = 1000;
   localparam int FAST_PERIOD_MS = 500;
   localparam int SLOW_HALF_CYC = (CLK_HZ / 1000) * SLOW_PERIOD_MS / 2;
   localparam int FAST_HALF_CYC = (CLK_HZ / 1000) * FAST_PERIOD_MS / 2;
   localparam int SETTLE_CYC = 3;
   // register byte offsets
   localparam logic [4:0] REG_STATUS = 5'h00;
   localparam logic [4:0] REG_SWITCH = 5'h04;
   localparam logic [4:0] REG_MANCTL = 5'h08;
   localparam logic [4:0] REG_VCOUNT = 5'h0C;
   // manual control bits
   localparam int MC_GO = 0;
   localparam int MC_SAVE = 1;
   localparam int MC_BANK = 2;
   localparam int MC_PROG = 3;
   localparam int MC_COMB = 4;
   localparam logic [4:0] MANCTL_RST = 5'h00;
   // switch vector positions
   localparam int SW_LOAD = 0;
   localparam int SW_SAVE = 1;
   localparam int SW_MAN = 2;
   localparam int SW_PROG = 3;
   localparam int SW_TWE = 4;
   localparam int SW_MWE = 5;
   localparam int SW_BANK = 6;
   localparam int SW_COMB = 7;
   // error codes
   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_MODE = 3'h1;
   localparam logic [2:0] ERR_PROTECT = 3'h2;
   localparam logic [2:0] ERR_DATA = 3'h3;
   localparam logic [2:0] ERR_VERIFY = 3'h4;
   // transfer areas
   localparam logic [1:0] AREA_PROG = 2'h0;
   localparam logic [1:0] AREA_SCREEN = 2'h1;
   localparam logic [1:0] AREA_MEMSW = 2'h2;
   // controller states
   typedef enum logic [2:0] {
      ST_CAPTURE, ST_IDLE, ST_PREP, ST_XMIT, ST_VERIFY, ST_DONE, ST_ERROR
   } bmtc_state_t;
endpackage

/* shared/bmtc_stream_if.sv */
// bmtc_stream_if: valid/ready word stream between the controller and its fifo
// assumes both ends on the same clock
`timescale 1ns/1ps
interface bmtc_stream_if #(parameter int W = 32);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* hw/bmtc_fifo.sv */
// bmtc_fifo: synchronous fifo, width and depth by parameter
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
module bmtc_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill and drain sides
   bmtc_stream_if.snk wr,
   bmtc_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   // handshakes and honest full/empty
   assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
   assign rd.valid = (cnt_q != '0);
   assign rd.data = mem_q[rp_q];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   // pointer and count update
   always_comb
   begin
      wp_d = push ? ((wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
      rp_d = pop ? ((rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   // registers and storage
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
      if (push)
         mem_q[wp_q] <= wr.data;
   end

   // a full fifo refuses data
   property p_full_refuses;
      @(posedge clk_i) disable iff (rst_i)
      (cnt_q == (AW+1)'(DEPTH)) |-> !wr.ready;
   endproperty
   a_full_refuses: assert property (p_full_refuses) else $error("fifo full but ready");
endmodule

/* hw/bmtc_top.sv */
// bmtc_top: startup transfer controller between terminal and backup module
// assumes switch, presence and bank tag pins are asynchronous; streams and
// readback come from logic on clk_i; registers on classic wishbone
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Behaviour
// - switches sampled once at startup, held
// - three mode switches: load, save, manual
// - not exactly one mode: mode error
// - data type switch: screen off, program on
// - two protect switches gate destination writes
// - protected destination gives protect error
// - bank switch picks bank zero or one
// - combined switch moves program and screen together
// - wrong data type into area: data error
// - writing a bank leaves other untouched
// - save ignores terminal configuration state
// - module mounted blocks normal operation
// - memory switch settings travel with screen
// - combined save: program bank zero, screen one; combined load follows the bank tags
// - combined load needs exactly one program bank
// - lamp slow preparing, fast transferring, lit done
module bmtc_top #(
   parameter int W = 32,
   parameter int XFER_WORDS = 256,
   parameter int FIFO_DEPTH = 16,
   parameter int SLOW_HALF = bmtc_pkg::SLOW_HALF_CYC,
   parameter int FAST_HALF = bmtc_pkg::FAST_HALF_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // module switches and presence pins
   input wire logic auto_load_to_terminal_sw_i,
   input wire logic auto_save_to_module_sw_i,
   input wire logic manual_transfer_sw_i,
   input wire logic data_type_sel_sw_i,
   input wire logic terminal_write_enable_sw_i,
   input wire logic module_write_enable_sw_i,
   input wire logic bank_select_sw_i,
   input wire logic combined_transfer_sw_i,
   input wire logic module_present_i,
   input wire logic [1:0] bank_has_prog_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // transfer descriptor
   output logic xfer_save_o,
   output logic [1:0] xfer_area_o,
   output logic xfer_bank_o,
   // source stream
   input wire logic src_valid_i,
   input wire logic [W-1:0] src_data_i,
   output logic src_ready_o,
   // destination stream
   output logic dst_valid_o,
   output logic [W-1:0] dst_data_o,
   input wire logic dst_ready_i,
   // destination readback
   input wire logic rb_valid_i,
   input wire logic [W-1:0] rb_data_i,
   output logic rb_ready_o,
   // operator outputs
   output logic run_lamp_o,
   output logic buzzer_o,
   output logic run_allowed_o
);
   localparam int CW = $clog2(XFER_WORDS + 1);
   bmtc_pkg::bmtc_state_t st_q, st_d;
   logic [10:0] s1_q, s2_q;
   logic [7:0] cfg_q, cfg_d;
   logic present_q, present_d;
   logic [1:0] set_q, set_d;
   logic [2:0] err_q, err_d;
   logic save_q, save_d, pbank_q, pbank_d, sbank_q, sbank_d;
   logic [1:0] base_q, base_d, idx_q, idx_d;
   logic [CW-1:0] scnt_q, scnt_d, dcnt_q, dcnt_d, vcnt_q, vcnt_d;
   logic [W-1:0] xsum_q, xsum_d, vsum_q, vsum_d;
   logic [4:0] man_q, man_d;
   logic go_q, go_d, ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d, lcnt_q, lcnt_d;
   logic lamp_q, lamp_d;
   logic e_save, e_prog, e_bank, e_comb, mode_ok, prot_ok, data_ok;
   logic src_fire, dst_fire, rb_fire, wb_req;
   logic [1:0] area;
   logic [31:0] half;
   bmtc_stream_if #(.W(W)) in_if ();
   bmtc_stream_if #(.W(W)) out_if ();

   // two-flop synchronisers for the pins
   always_ff @(posedge clk_i)
   begin
      s1_q <= {bank_has_prog_i, module_present_i, combined_transfer_sw_i, bank_select_sw_i,
               module_write_enable_sw_i, terminal_write_enable_sw_i, data_type_sel_sw_i,
               manual_transfer_sw_i, auto_save_to_module_sw_i, auto_load_to_terminal_sw_i};
      s2_q <= s1_q;
   end

   // effective transfer settings, switches or touch panel
   always_comb
   begin
      mode_ok = $onehot(cfg_q[2:0]);
      if (cfg_q[bmtc_pkg::SW_MAN])
      begin
         e_save = man_q[bmtc_pkg::MC_SAVE];
         e_prog = man_q[bmtc_pkg::MC_PROG];
         e_bank = man_q[bmtc_pkg::MC_BANK];
         e_comb = man_q[bmtc_pkg::MC_COMB];
      end
      else
      begin
         e_save = cfg_q[bmtc_pkg::SW_SAVE];
         e_prog = cfg_q[bmtc_pkg::SW_PROG];
         e_bank = cfg_q[bmtc_pkg::SW_BANK];
         e_comb = cfg_q[bmtc_pkg::SW_COMB];
      end
      prot_ok = e_save ? cfg_q[bmtc_pkg::SW_MWE] : cfg_q[bmtc_pkg::SW_TWE];
      if (e_save)
         data_ok = 1'b1;
      else if (e_comb)
         data_ok = ^s2_q[10:9];
      else
         data_ok = (s2_q[9 + e_bank] == e_prog);
   end

   // segment descriptor: program, screen, memory switch settings
   assign area = base_q + idx_q;
   assign xfer_area_o = area;
   assign xfer_save_o = save_q;
   assign xfer_bank_o = (area == bmtc_pkg::AREA_PROG) ? pbank_q : sbank_q;
   // streams, only open while transmitting or verifying
   assign in_if.valid = src_valid_i && (st_q == bmtc_pkg::ST_XMIT) && (scnt_q < CW'(XFER_WORDS));
   assign in_if.data = src_data_i;
   assign src_ready_o = in_if.ready && (st_q == bmtc_pkg::ST_XMIT) && (scnt_q < CW'(XFER_WORDS));
   assign dst_valid_o = out_if.valid && (st_q == bmtc_pkg::ST_XMIT);
   assign dst_data_o = out_if.data;
   assign out_if.ready = dst_ready_i && (st_q == bmtc_pkg::ST_XMIT);
   assign rb_ready_o = (st_q == bmtc_pkg::ST_VERIFY);
   assign src_fire = in_if.valid && in_if.ready;
   assign dst_fire = dst_valid_o && dst_ready_i;
   assign rb_fire = rb_valid_i && rb_ready_o;
   assign buzzer_o = (st_q == bmtc_pkg::ST_ERROR);
   assign run_allowed_o = (st_q == bmtc_pkg::ST_IDLE) && !present_q;

   bmtc_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr(in_if),
      .rd(out_if)
   );

   // transfer sequencer next state
   always_comb
   begin
      st_d = st_q;
      cfg_d = cfg_q;
      present_d = present_q;
      set_d = set_q;
      err_d = err_q;
      save_d = save_q;
      pbank_d = pbank_q;
      sbank_d = sbank_q;
      base_d = base_q;
      idx_d = idx_q;
      scnt_d = src_fire ? scnt_q + 1'b1 : scnt_q;
      dcnt_d = dst_fire ? dcnt_q + 1'b1 : dcnt_q;
      xsum_d = src_fire ? xsum_q ^ src_data_i : xsum_q;
      vcnt_d = rb_fire ? vcnt_q + 1'b1 : vcnt_q;
      vsum_d = rb_fire ? vsum_q ^ rb_data_i : vsum_q;
      case (st_q)
         bmtc_pkg::ST_CAPTURE:
         begin
            set_d = set_q + 1'b1;
            if (set_q == 2'(bmtc_pkg::SETTLE_CYC - 1))
            begin
               cfg_d = s2_q[7:0];
               present_d = s2_q[8];
               st_d = (s2_q[8] && !s2_q[bmtc_pkg::SW_MAN]) ? bmtc_pkg::ST_PREP : bmtc_pkg::ST_IDLE;
            end
         end
         bmtc_pkg::ST_IDLE:
            if (present_q && go_q && cfg_q[bmtc_pkg::SW_MAN])
               st_d = bmtc_pkg::ST_PREP;
         bmtc_pkg::ST_PREP:
         begin
            save_d = e_save;
            base_d = (e_comb || e_prog) ? bmtc_pkg::AREA_PROG : bmtc_pkg::AREA_SCREEN;
            idx_d = '0;
            if (e_comb && e_save)
            begin
               pbank_d = 1'b0;
               sbank_d = 1'b1;
            end
            else if (e_comb)
            begin
               pbank_d = s2_q[10];
               sbank_d = !s2_q[10];
            end
            else
            begin
               pbank_d = e_bank;
               sbank_d = e_bank;
            end
            if (!mode_ok)
               err_d = bmtc_pkg::ERR_MODE;
            else if (!prot_ok)
               err_d = bmtc_pkg::ERR_PROTECT;
            else if (!data_ok)
               err_d = bmtc_pkg::ERR_DATA;
            st_d = (mode_ok && prot_ok && data_ok) ? bmtc_pkg::ST_XMIT : bmtc_pkg::ST_ERROR;
            scnt_d = '0;
            dcnt_d = '0;
            xsum_d = '0;
         end
         bmtc_pkg::ST_XMIT:
            if (dcnt_q == CW'(XFER_WORDS))
            begin
               st_d = bmtc_pkg::ST_VERIFY;
               vcnt_d = '0;
               vsum_d = '0;
            end
         bmtc_pkg::ST_VERIFY:
            if (vcnt_q == CW'(XFER_WORDS))
            begin
               scnt_d = '0;
               dcnt_d = '0;
               xsum_d = '0;
               if (vsum_q != xsum_q)
               begin
                  err_d = bmtc_pkg::ERR_VERIFY;
                  st_d = bmtc_pkg::ST_ERROR;
               end
               else if (area == bmtc_pkg::AREA_PROG && base_q == bmtc_pkg::AREA_PROG && !e_comb)
                  st_d = bmtc_pkg::ST_DONE;
               else if (area == bmtc_pkg::AREA_MEMSW)
                  st_d = bmtc_pkg::ST_DONE;
               else
               begin
                  idx_d = idx_q + 1'b1;
                  st_d = bmtc_pkg::ST_XMIT;
               end
            end
         bmtc_pkg::ST_DONE,
         bmtc_pkg::ST_ERROR:
            st_d = st_q;
         default:
            st_d = bmtc_pkg::ST_ERROR;
      endcase
   end

   // transfer sequencer registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= bmtc_pkg::ST_CAPTURE;
         cfg_q <= '0;
         present_q <= 1'b0;
         set_q <= '0;
         err_q <= bmtc_pkg::ERR_NONE;
         save_q <= 1'b0;
         pbank_q <= 1'b0;
         sbank_q <= 1'b0;
         base_q <= bmtc_pkg::AREA_PROG;
         idx_q <= '0;
         scnt_q <= '0;
         dcnt_q <= '0;
         xsum_q <= '0;
         vcnt_q <= '0;
         vsum_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         cfg_q <= cfg_d;
         present_q <= present_d;
         set_q <= set_d;
         err_q <= err_d;
         save_q <= save_d;
         pbank_q <= pbank_d;
         sbank_q <= sbank_d;
         base_q <= base_d;
         idx_q <= idx_d;
         scnt_q <= scnt_d;
         dcnt_q <= dcnt_d;
         xsum_q <= xsum_d;
         vcnt_q <= vcnt_d;
         vsum_q <= vsum_d;
      end
   end

   // run lamp: slow flash preparing, fast flash moving data or error
   always_comb
   begin
      half = (st_q == bmtc_pkg::ST_PREP) ? 32'(SLOW_HALF) : 32'(FAST_HALF);
      lcnt_d = (lcnt_q >= half - 32'h1) ? 32'h0 : lcnt_q + 32'h1;
      lamp_d = (lcnt_q >= half - 32'h1) ? !lamp_q : lamp_q;
      case (st_q)
         bmtc_pkg::ST_PREP, bmtc_pkg::ST_XMIT, bmtc_pkg::ST_VERIFY, bmtc_pkg::ST_ERROR:
            run_lamp_o = lamp_q;
         bmtc_pkg::ST_DONE:
            run_lamp_o = 1'b1;
         default:
            run_lamp_o = cfg_q[bmtc_pkg::SW_MAN] && present_q;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lcnt_q <= '0;
         lamp_q <= 1'b0;
      end
      else
      begin
         lcnt_q <= lcnt_d;
         lamp_q <= lamp_d;
      end
   end

   // wishbone slave, ack one cycle after the request
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   always_comb
   begin
      ack_d = wb_req;
      man_d = man_q;
      go_d = 1'b0;
      rdat_d = 32'h0;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == bmtc_pkg::REG_MANCTL)
      begin
         man_d = {wb_dat_i[4:1], 1'b0};
         go_d = wb_dat_i[bmtc_pkg::MC_GO];
      end
      if (wb_req && !wb_we_i)
         case (wb_adr_i)
            bmtc_pkg::REG_STATUS:
               rdat_d = {19'h0, present_q, 2'h0, idx_q, 1'b0, err_q, 1'b0, st_q};
            bmtc_pkg::REG_SWITCH:
               rdat_d = {21'h0, s2_q};
            bmtc_pkg::REG_MANCTL:
               rdat_d = {27'h0, man_q};
            bmtc_pkg::REG_VCOUNT:
               rdat_d = 32'(vcnt_q);
            default:
               rdat_d = 32'h0;
         endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         man_q <= bmtc_pkg::MANCTL_RST;
         go_q <= 1'b0;
         rdat_q <= '0;
      end
      else
      begin
         ack_q <= ack_d;
         man_q <= man_d;
         go_q <= go_d;
         rdat_q <= rdat_d;
      end
   end

   // configuration never changes after capture
   property p_cfg_held;
      @(posedge clk_i) disable iff (rst_i)
      (st_q != bmtc_pkg::ST_CAPTURE) && ($past(st_q) != bmtc_pkg::ST_CAPTURE) |-> $stable(cfg_q);
   endproperty
   a_cfg_held: assert property (p_cfg_held) else $error("config changed");
   // bad mode selection ends in a mode error
   property p_mode_err;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == bmtc_pkg::ST_PREP) && !$onehot(cfg_q[2:0]) |=>
         (st_q == bmtc_pkg::ST_ERROR) && (err_q == bmtc_pkg::ERR_MODE);
   endproperty
   a_mode_err: assert property (p_mode_err) else $error("no mode error");
   // protected destination ends in a protect error
   property p_prot_err;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == bmtc_pkg::ST_PREP) && $onehot(cfg_q[2:0]) && !prot_ok |=> err_q == bmtc_pkg::ERR_PROTECT;
   endproperty
   a_prot_err: assert property (p_prot_err) else $error("no protect error");
   // wrong data type ends in a data error
   property p_data_err;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == bmtc_pkg::ST_PREP) && mode_ok && prot_ok && !data_ok |=> err_q == bmtc_pkg::ERR_DATA;
   endproperty
   a_data_err: assert property (p_data_err) else $error("no data error");
   // error state holds and never writes
   property p_err_hold;
      @(posedge clk_i) disable iff (rst_i)
      st_q == bmtc_pkg::ST_ERROR |=> (st_q == bmtc_pkg::ST_ERROR) && !dst_valid_o && $stable(err_q);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error not held");
   // verify only follows transmit
   property p_order;
      @(posedge clk_i) disable iff (rst_i)
      $rose(st_q == bmtc_pkg::ST_VERIFY) |-> $past(st_q) == bmtc_pkg::ST_XMIT;
   endproperty
   a_order: assert property (p_order) else $error("verify out of order");
   // combined save puts program in bank zero
   property p_comb_bank;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == bmtc_pkg::ST_XMIT) && save_q && e_comb && area == bmtc_pkg::AREA_PROG |-> !xfer_bank_o;
   endproperty
   a_comb_bank: assert property (p_comb_bank) else $error("program not in bank 0");
   // finished lamp steady on, no run while mounted
   property p_done_lamp;
      @(posedge clk_i) disable iff (rst_i)
      st_q == bmtc_pkg::ST_DONE |-> run_lamp_o && !run_allowed_o;
   endproperty
   a_done_lamp: assert property (p_done_lamp) else $error("done lamp wrong");
endmodule

/* tb/bmtc_module_model.sv */
// bmtc_module_model: far side of the transfer streams, with two bank write counters
// assumes the controller drives descriptor and streams on the same clock
`timescale 1ns/1ps
module bmtc_module_model #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bench control
   input wire logic stall_i,
   // descriptor
   input wire logic save_i,
   input wire logic bank_i,
   // streams
   output logic src_valid_o,
   output logic [W-1:0] src_data_o,
   input wire logic src_ready_i,
   input wire logic dst_valid_i,
   input wire logic [W-1:0] dst_data_i,
   output logic dst_ready_o,
   output logic rb_valid_o,
   output logic [W-1:0] rb_data_o,
   input wire logic rb_ready_i,
   // stored word counts
   output logic [7:0] n_b0_o,
   output logic [7:0] n_b1_o,
   output logic [7:0] n_all_o
);
   logic [W-1:0] mem [0:255];
   logic [7:0] rp;
   logic [1:0] ph;
   // source always holds a program of the terminal's own type
   assign src_valid_o = 1'b1;
   // readback replays stored words; when empty it shows a changing pattern
   assign rb_valid_o = rp != n_all_o;
   assign rb_data_o = rb_valid_o ? mem[rp] : {W{ph[0]}};
   // slow mode takes one word in four
   assign dst_ready_o = !stall_i || ph == 2'h3;
   // store, count per bank and replay
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ph <= 2'h0;
         rp <= 8'h00;
         n_all_o <= 8'h00;
         n_b0_o <= 8'h00;
         n_b1_o <= 8'h00;
         src_data_o <= 32'h00001000;
      end
      else
      begin
         ph <= ph + 2'h1;
         if (src_ready_i)
            src_data_o <= src_data_o + 32'h00000001;
         if (dst_valid_i && dst_ready_o)
         begin
            mem[n_all_o] <= dst_data_i;
            n_all_o <= n_all_o + 8'h01;
            if (save_i && !bank_i)
               n_b0_o <= n_b0_o + 8'h01;
            if (save_i && bank_i)
               n_b1_o <= n_b1_o + 8'h01;
         end
         if (rb_valid_o && rb_ready_i)
            rp <= rp + 8'h01;
      end
   end
endmodule

/* tb/bmtc_top_test.sv */
// bmtc_top_test: self-checking bench for the startup transfer controller
// assumes the far side model and short lamp and word counts
`timescale 1ns/1ps
module bmtc_top_test;
   localparam int N = 40;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] sw = 8'h00;
   logic present = 1'b0;
   logic [1:0] has_prog = 2'h0;
   logic stall = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, xfer_save_o, xfer_bank_o, src_valid, src_ready, dst_valid, dst_ready;
   logic rb_valid, rb_ready, run_lamp_o, buzzer_o, run_allowed_o;
   logic [1:0] xfer_area_o;
   logic [31:0] src_data, dst_data, rb_data;
   logic [7:0] n_b0, n_b1, n_all;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   // clock
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   bmtc_top #(.XFER_WORDS(N), .SLOW_HALF(8), .FAST_HALF(4)) bmtc_top_i (.clk_i(clk_i), .rst_i(rst_i),
      .auto_load_to_terminal_sw_i(sw[0]), .auto_save_to_module_sw_i(sw[1]), .manual_transfer_sw_i(sw[2]),
      .data_type_sel_sw_i(sw[3]), .terminal_write_enable_sw_i(sw[4]), .module_write_enable_sw_i(sw[5]),
      .bank_select_sw_i(sw[6]), .combined_transfer_sw_i(sw[7]), .module_present_i(present),
      .bank_has_prog_i(has_prog), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xfer_save_o(xfer_save_o),
      .xfer_area_o(xfer_area_o), .xfer_bank_o(xfer_bank_o), .src_valid_i(src_valid), .src_data_i(src_data),
      .src_ready_o(src_ready), .dst_valid_o(dst_valid), .dst_data_o(dst_data), .dst_ready_i(dst_ready),
      .rb_valid_i(rb_valid), .rb_data_i(rb_data), .rb_ready_o(rb_ready), .run_lamp_o(run_lamp_o),
      .buzzer_o(buzzer_o), .run_allowed_o(run_allowed_o));
   bmtc_module_model bmtc_module_model_i (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
      .save_i(xfer_save_o), .bank_i(xfer_bank_o), .src_valid_o(src_valid), .src_data_o(src_data),
      .src_ready_i(src_ready), .dst_valid_i(dst_valid), .dst_data_i(dst_data), .dst_ready_o(dst_ready),
      .rb_valid_o(rb_valid), .rb_data_o(rb_data), .rb_ready_i(rb_ready), .n_b0_o(n_b0), .n_b1_o(n_b1),
      .n_all_o(n_all));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // timeout watchdog
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   // classic wishbone single cycle
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
      chk(wb_ack_o, 1'b0, "ack drop");
   endtask
   task automatic start(input logic [7:0] s, input logic p, input logic [1:0] hp, input logic st);
      @(posedge clk_i);
      rst_i <= 1'b1;
      sw <= s;
      present <= p;
      has_prog <= hp;
      stall <= st;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic expect_end(input string name, input logic [2:0] err, input logic [7:0] b0,
      input logic [7:0] b1, input logic [7:0] all);
      int k;
      logic lamp;
      k = 0;
      rdat = 32'h00000000;
      while (rdat[2:0] != bmtc_pkg::ST_DONE && rdat[2:0] != bmtc_pkg::ST_ERROR && k < 600)
      begin
         wb(1'b0, bmtc_pkg::REG_STATUS, 32'h00000000);
         k++;
      end
      chk(rdat[2:0], err == 3'h0 ? bmtc_pkg::ST_DONE : bmtc_pkg::ST_ERROR, "state");
      chk(rdat[6:4], err, "error code");
      chk(buzzer_o, err != 3'h0, "buzzer");
      chk(run_allowed_o, 1'b0, "run allowed");
      chk({n_b0, n_b1, n_all}, {b0, b1, all}, "stored words");
      lamp = run_lamp_o;
      repeat (3)
      begin
         @(posedge clk_i);
         if (err == 3'h0)
            chk(run_lamp_o, 1'b1, "lamp steady");
      end
      @(posedge clk_i);
      if (err != 3'h0)
         chk(run_lamp_o, !lamp, "lamp flashing");
      else
         chk(xfer_area_o, bmtc_pkg::AREA_MEMSW, "last segment");
      $display("test %s done", name);
   endtask
   task automatic t_no_module;
      start(8'h01, 1'b0, 2'h0, 1'b0);
      repeat (8) @(posedge clk_i);
      wb(1'b0, bmtc_pkg::REG_STATUS, 32'h00000000);
      chk(rdat[2:0], bmtc_pkg::ST_IDLE, "idle");
      chk(run_allowed_o, 1'b1, "run allowed");
      wb(1'b0, bmtc_pkg::REG_SWITCH, 32'h00000000);
      chk(rdat[10:0], 11'h001, "switch view");
      wb(1'b0, 5'h10, 32'h00000000);
      chk(rdat, 32'h00000000, "unmapped");
      $display("test no_module done");
   endtask
   task automatic t_errors;
      start(8'h30, 1'b1, 2'h0, 1'b0);
      expect_end("mode_none", 3'h1, 8'h00, 8'h00, 8'h00);
      start(8'h33, 1'b1, 2'h0, 1'b0);
      expect_end("mode_two", 3'h1, 8'h00, 8'h00, 8'h00);
      start(8'h12, 1'b1, 2'h0, 1'b0);
      expect_end("protect_module", 3'h2, 8'h00, 8'h00, 8'h00);
      start(8'h21, 1'b1, 2'h0, 1'b0);
      expect_end("protect_terminal", 3'h2, 8'h00, 8'h00, 8'h00);
      start(8'h19, 1'b1, 2'h0, 1'b0);
      expect_end("data_type", 3'h3, 8'h00, 8'h00, 8'h00);
      start(8'h91, 1'b1, 2'h3, 1'b0);
      expect_end("combined_tags", 3'h3, 8'h00, 8'h00, 8'h00);
   endtask
   task automatic t_save;
      start(8'h62, 1'b1, 2'h0, 1'b1);
      repeat (6) @(posedge clk_i);
      sw <= 8'h00;
      expect_end("save_bank1", 3'h0, 8'h00, 2 * N, 2 * N);
      start(8'hE2, 1'b1, 2'h0, 1'b1);
      expect_end("save_combined", 3'h0, N, 2 * N, 3 * N);
   endtask
   task automatic t_load;
      start(8'h51, 1'b1, 2'h0, 1'b0);
      expect_end("load_screen", 3'h0, 8'h00, 8'h00, 2 * N);
      start(8'h91, 1'b1, 2'h1, 1'b0);
      expect_end("load_combined", 3'h0, 8'h00, 8'h00, 3 * N);
   endtask
   task automatic t_manual;
      start(8'h24, 1'b1, 2'h0, 1'b0);
      repeat (8) @(posedge clk_i);
      wb(1'b0, bmtc_pkg::REG_STATUS, 32'h00000000);
      chk(rdat[2:0], bmtc_pkg::ST_IDLE, "manual waits");
      wb(1'b1, bmtc_pkg::REG_MANCTL, 32'h00000003);
      expect_end("manual_save", 3'h0, 2 * N, 8'h00, 2 * N);
   endtask
   // main sequence
   initial
   begin
      t_no_module();
      t_errors();
      t_save();
      t_load();
      t_manual();
      print_verdict();
   end
endmodule
